// file: inc/sia_pkg.sv
// Constants for the status interrupt arm and test access block.
// Assumes a 32-bit APB register bus and a single core clock.
package sia_pkg;
  // Printed offsets (test window 0x04, select 0x07) are not all word
  // aligned, so each is kept as an index and the byte address is 4*index.
  localparam logic [7:0] IDX_TEST_DATA = 8'h04;
  localparam logic [7:0] IDX_TEST_SEL = 8'h07;
  localparam logic [7:0] IDX_ARMS = 8'h0F;
  localparam logic [7:0] IDX_STATUS = 8'h10;
  localparam logic [7:0] IDX_MASK = 8'h11;
  localparam logic [7:0] IDX_PINS = 8'h12;
  localparam logic [11:0] ADDR_TEST_DATA = {2'b00, IDX_TEST_DATA, 2'b00};
  localparam logic [11:0] ADDR_TEST_SEL = {2'b00, IDX_TEST_SEL, 2'b00};
  localparam logic [11:0] ADDR_ARMS = {2'b00, IDX_ARMS, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};
  localparam logic [11:0] ADDR_MASK = {2'b00, IDX_MASK, 2'b00};
  localparam logic [11:0] ADDR_PINS = {2'b00, IDX_PINS, 2'b00};
  localparam int REG_W = 16;
  localparam int SEL_W = 5;
  localparam int NUM_TEST = 32;
  localparam int NUM_PINS = 6;
  localparam logic [15:0] ARMS_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [4:0] SEL_RST = 5'h00;
  localparam logic [15:0] TEST_RST = 16'h0000;
  localparam logic [5:0] PINS_RST = 6'h3F;
  // Status bit positions; pin i sets status bit 15-2*i, armed by bits
  // 15-2*i (fall) and 14-2*i (rise).
  localparam int ST_RCC_UNDER = 3;
  localparam int ST_DPLL_LOSS = 2;
  localparam int ST_BAUD_SECOND = 1;
  localparam int ST_BAUD_FIRST = 0;
  localparam int PIN_TOP = 15;
  typedef enum logic [1:0] {APB_IDLE, APB_DONE} sia_apb_t;
endpackage

// file: rtl/sia_edge.sv
// Edge detector with fall and rise arms for one active-low pin.
// Assumes the pin is synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module sia_edge (
  input wire logic CORE_CLK, // Core clock
  input wire logic RST, // Synchronous reset, active high
  input wire logic PIN, // Pin level
  input wire logic FALL_ARM, // Arm for falling transitions
  input wire logic RISE_ARM, // Arm for rising transitions
  output logic HIT // One-cycle armed edge pulse
);
  import sia_pkg::*;
  logic prev_r;
  // Pins idle high, so resetting to one avoids a false rise at start-up
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= PIN;
    end
  end
  assign HIT = (FALL_ARM & prev_r & ~PIN) | (RISE_ARM & ~prev_r & PIN);
endmodule // sia_edge
`default_nettype wire

// file: rtl/sia_top.sv
// Status interrupt arming, sticky status, mask and test register window.
// Assumes an APB master on the core clock and pins synchronous to it.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module sia_top (
  input wire logic CORE_CLK, // Core clock, 100 MHz
  input wire logic RST, // Synchronous reset, active high
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction
  input wire logic [11:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error for unmapped address
  input wire logic RECEIVE_CLOCK_PIN_N, // Receive clock pin
  input wire logic TRANSMIT_CLOCK_PIN_N, // Transmit clock pin
  input wire logic RECEIVE_DMA_REQUEST_PIN_N, // Receive request pin
  input wire logic TRANSMIT_DMA_REQUEST_PIN_N, // Transmit request pin
  input wire logic CARRIER_DETECT_PIN_N, // Carrier detect pin
  input wire logic CLEAR_TO_SEND_PIN_N, // Clear-to-send pin
  input wire logic RECEIVE_CHAR_COUNT_UNDER, // Count underflow pulse
  input wire logic RECEIVE_CHAR_COUNT_USED, // Count facility in use
  input wire logic BIPHASE_MODE, // Biphase encoding selected
  input wire logic DPLL_SYNC_LOSS, // Loop sync loss pulse
  input wire logic BAUD_GEN_SECOND_ZERO, // Second counter at zero
  input wire logic BAUD_GEN_FIRST_ZERO, // First counter at zero
  output logic IRQ // Level interrupt, high while unmasked status set
);
  import sia_pkg::*;

  logic [15:0] status_interrupt_arms_r;
  logic [15:0] misc_status_latch_r;
  logic [15:0] mask_r;
  logic [SEL_W-1:0] test_select_r;
  logic [REG_W-1:0] test_regs_r [NUM_TEST];
  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] hit;
  logic [15:0] set_nxt;
  logic [15:0] clr_nxt;
  logic [31:0] rdata_nxt;
  logic err_nxt;
  logic access;
  logic wr_en;
  sia_apb_t apb_r;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == ADDR_TEST_DATA) || (a == ADDR_TEST_SEL) ||
      (a == ADDR_ARMS) || (a == ADDR_STATUS) || (a == ADDR_MASK) ||
      (a == ADDR_PINS);
  endfunction

  assign pins = {CLEAR_TO_SEND_PIN_N, CARRIER_DETECT_PIN_N,
    TRANSMIT_DMA_REQUEST_PIN_N, RECEIVE_DMA_REQUEST_PIN_N,
    TRANSMIT_CLOCK_PIN_N, RECEIVE_CLOCK_PIN_N};

  // One edge detector per pin, arms taken pairwise from the top
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      sia_edge u_edge (
        .CORE_CLK(CORE_CLK),
        .RST(RST),
        .PIN(pins[gi]),
        .FALL_ARM(status_interrupt_arms_r[PIN_TOP-2*gi]),
        .RISE_ARM(status_interrupt_arms_r[PIN_TOP-1-2*gi]),
        .HIT(hit[gi])
      );
    end
  endgenerate

  // Access phase of a transfer; the registered ready adds one wait state
  assign access = PSEL & PENABLE & (apb_r == APB_IDLE);
  assign wr_en = access & PWRITE;

  always_comb begin
    set_nxt = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      set_nxt[PIN_TOP-2*i] = hit[i];
    end
    set_nxt[ST_RCC_UNDER] = status_interrupt_arms_r[ST_RCC_UNDER] &
      RECEIVE_CHAR_COUNT_USED & RECEIVE_CHAR_COUNT_UNDER;
    set_nxt[ST_DPLL_LOSS] = status_interrupt_arms_r[ST_DPLL_LOSS] &
      BIPHASE_MODE & DPLL_SYNC_LOSS;
    set_nxt[ST_BAUD_SECOND] = status_interrupt_arms_r[ST_BAUD_SECOND] &
      BAUD_GEN_SECOND_ZERO;
    set_nxt[ST_BAUD_FIRST] = status_interrupt_arms_r[ST_BAUD_FIRST] &
      BAUD_GEN_FIRST_ZERO;
  end

  always_comb begin
    clr_nxt = '0;
    if (wr_en && PADDR == ADDR_STATUS) begin
      clr_nxt = PWDATA[15:0];
    end
  end

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      misc_status_latch_r <= STATUS_RST;
    end else begin
      misc_status_latch_r <= (misc_status_latch_r & ~clr_nxt) | set_nxt;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      status_interrupt_arms_r <= ARMS_RST;
    end else if (wr_en && PADDR == ADDR_ARMS) begin
      status_interrupt_arms_r <= PWDATA[15:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mask_r <= MASK_RST;
    end else if (wr_en && PADDR == ADDR_MASK) begin
      mask_r <= PWDATA[15:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      test_select_r <= SEL_RST;
    end else if (wr_en && PADDR == ADDR_TEST_SEL) begin
      test_select_r <= PWDATA[SEL_W-1:0];
    end
  end

  // Test registers held as an array, reached only through the window
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      for (int i = 0; i < NUM_TEST; i++) begin
        test_regs_r[i] <= TEST_RST;
      end
    end else if (wr_en && PADDR == ADDR_TEST_DATA) begin
      test_regs_r[test_select_r] <= PWDATA[15:0];
    end
  end

  always_comb begin
    rdata_nxt = '0;
    unique case (PADDR)
      ADDR_TEST_DATA: rdata_nxt[15:0] = test_regs_r[test_select_r];
      ADDR_TEST_SEL: rdata_nxt[SEL_W-1:0] = test_select_r;
      ADDR_ARMS: rdata_nxt[15:0] = status_interrupt_arms_r;
      ADDR_STATUS: rdata_nxt[15:0] = misc_status_latch_r;
      ADDR_MASK: rdata_nxt[15:0] = mask_r;
      ADDR_PINS: rdata_nxt[NUM_PINS-1:0] = pins;
      default: rdata_nxt = '0;
    endcase
  end

  assign err_nxt = ~mapped(PADDR);

  // Ready is registered: one wait state, then a single ready cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      apb_r <= APB_IDLE;
    end else begin
      unique case (apb_r)
        APB_IDLE: apb_r <= (PSEL && PENABLE) ? APB_DONE : APB_IDLE;
        APB_DONE: apb_r <= APB_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
    end else begin
      PREADY <= access;
      PSLVERR <= access & err_nxt;
      PRDATA <= (access && !PWRITE) ? rdata_nxt : '0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(misc_status_latch_r & mask_r);
    end
  end
endmodule // sia_top
`default_nettype wire

// file: sim/sia_properties.sv
// Checker for the arm, status and APB timing of sia_top.
// Assumes a bind to sia_top; pins are synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module sia_props import sia_pkg::*; (
  input wire logic CORE_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, IRQ,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic RECEIVE_CLOCK_PIN_N, TRANSMIT_CLOCK_PIN_N,
  input wire logic RECEIVE_DMA_REQUEST_PIN_N, TRANSMIT_DMA_REQUEST_PIN_N,
  input wire logic CARRIER_DETECT_PIN_N, CLEAR_TO_SEND_PIN_N
);
  logic [15:0] arm_r, msk_r;
  logic [5:0] prv_r, pv, hit;
  wire logic wr = PSEL && PENABLE && PWRITE;
  assign pv = {CLEAR_TO_SEND_PIN_N, CARRIER_DETECT_PIN_N,
    TRANSMIT_DMA_REQUEST_PIN_N, RECEIVE_DMA_REQUEST_PIN_N,
    TRANSMIT_CLOCK_PIN_N, RECEIVE_CLOCK_PIN_N};
  // Shadow copies of arms and mask, so only unmasked armed edges count
  for (genvar i = 0; i < 6; i++) begin : g_hit
    assign hit[i] = msk_r[15-2*i] & (prv_r[i] & ~pv[i] & arm_r[15-2*i]
      | ~prv_r[i] & pv[i] & arm_r[14-2*i]);
  end
  always_ff @(posedge CORE_CLK) begin
    prv_r <= RST ? 6'h3F : pv;
    if (RST) arm_r <= 16'h0000;
    else if (wr && PADDR == ADDR_ARMS) arm_r <= PWDATA[15:0];
    if (RST) msk_r <= 16'h0000;
    else if (wr && PADDR == ADDR_MASK) msk_r <= PWDATA[15:0];
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  a_ready_one_wait: assert property ($rose(PSEL && PENABLE) |=> PREADY)
    else $error("ready late");
  a_ready_one_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  a_rxc_edge_irq: assert property (hit[0] |-> ##[1:3] IRQ)
    else $error("rxc edge lost");
  a_txc_edge_irq: assert property (hit[1] |-> ##[1:3] IRQ)
    else $error("txc edge lost");
  a_receive_dma_request_pin_edge_irq: assert property (hit[2] |-> ##[1:3] IRQ)
    else $error("receive_dma_request_pin edge lost");
  a_transmit_dma_request_pin_edge_irq: assert property (hit[3] |-> ##[1:3] IRQ)
    else $error("transmit_dma_request_pin edge lost");
  a_dcd_edge_irq: assert property (hit[4] |-> ##[1:3] IRQ)
    else $error("dcd edge lost");
  a_cts_edge_irq: assert property (hit[5] |-> ##[1:3] IRQ)
    else $error("cts edge lost");
  c_pin_hit: cover property (hit[0]);
  c_irq_up: cover property ($rose(IRQ));
  c_write: cover property (wr);
endmodule // sia_props
bind sia_top sia_props u_props (.*);
`default_nettype wire

// file: sim/sia_line_model.sv
// Far-side line model for clock, modem and request pins.
// Assumes the bench sets wanted levels; pins idle high after reset.
`timescale 1ns/1ps
`default_nettype none
module sia_line_model (
  input wire logic CORE_CLK, // Core clock
  input wire logic RST, // Reset, pins go idle
  input wire logic [5:0] LVL, // Wanted levels, rxc at bit 0
  output logic [5:0] PIN_N // Pin levels
);
  always_ff @(posedge CORE_CLK) begin
    PIN_N <= RST ? 6'h3F : LVL;
  end
endmodule // sia_line_model
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for sia_top over APB.
// Assumes the line model drives the pins; read notes queue up.
`timescale 1ns/1ps
`default_nettype none
module testbench import sia_pkg::*;;
  logic CORE_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic PREADY, PSLVERR, IRQ, RECEIVE_CHAR_COUNT_USED = 0, BIPHASE_MODE = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, x = 32'h0000_002C;
  logic [3:0] ev = 4'h0;
  logic [5:0] lvl = 6'h3F;
  wire logic [5:0] pn;
  logic [32:0] q[$];
  logic [15:0] tr[32];
  logic [11:0] ad[5] = '{ADDR_TEST_DATA, ADDR_TEST_SEL, ADDR_ARMS,
    ADDR_STATUS, ADDR_MASK};
  int fail_count = 0, comparisons = 0;
  always #5 CORE_CLK = ~CORE_CLK;
  sia_line_model u_line (.CORE_CLK(CORE_CLK), .RST(RST), .LVL(lvl),
    .PIN_N(pn));
  sia_top u_dut (.RECEIVE_CLOCK_PIN_N(pn[0]), .TRANSMIT_CLOCK_PIN_N(pn[1]),
    .RECEIVE_DMA_REQUEST_PIN_N(pn[2]), .TRANSMIT_DMA_REQUEST_PIN_N(pn[3]),
    .CARRIER_DETECT_PIN_N(pn[4]), .CLEAR_TO_SEND_PIN_N(pn[5]),
    .RECEIVE_CHAR_COUNT_UNDER(ev[3]), .DPLL_SYNC_LOSS(ev[2]),
    .BAUD_GEN_SECOND_ZERO(ev[1]), .BAUD_GEN_FIRST_ZERO(ev[0]), .*);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [32:0] e, g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // Reads leave {error, data} notes; the watcher below settles them
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge CORE_CLK);
    if (!w) q.push_back(e);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK) PENABLE <= 1;
    n = 0;
    do begin @(posedge CORE_CLK); n++; end while (!PREADY && n < 20);
    if (!PREADY) begin
      fail_count++;
      test_done();
    end
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  always @(posedge CORE_CLK) begin
    if (PREADY && !PWRITE) chk("read", q.pop_front(), {PSLVERR, PRDATA});
  end
  task automatic st(input logic [15:0] e);
    apb(0, ADDR_STATUS, 32'h0000_0000, {17'h0_0000, e});
    chk("irq", 33'(e != 16'h0000), 33'(IRQ));
    apb(1, ADDR_STATUS, {16'h0000, e}, 33'h0_0000_0000);
  endtask
  initial begin
    repeat (2) @(posedge CORE_CLK);
    RST <= 0;
    foreach (ad[i]) apb(0, ad[i], 0, 0);
    apb(0, ADDR_PINS, 0, 33'h0_0000_003F);
    apb(0, 12'h0FC, 0, 33'h1_0000_0000);
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      x = xs(x);
      tr[i] = x[15:0];
      apb(1, ADDR_TEST_SEL, {x[31:5], 5'(i)}, 0);
      apb(1, ADDR_TEST_DATA, x, 0);
      apb(0, ADDR_TEST_SEL, 0, 33'(i));
    end
    for (int i = 31; i >= 0; i--) begin
      apb(1, ADDR_TEST_SEL, 32'(i), 0);
      apb(0, ADDR_TEST_DATA, 0, {17'h0_0000, tr[i]});
    end
    $display("test window done");
    apb(1, ADDR_MASK, 32'h0000_FFFF, 0);
    for (int p = 0; p < 6; p++)
      for (int k = 0; k < 2; k++) begin
        apb(1, ADDR_ARMS, 32'h0000_0001 << (15 - 2 * p - k), 0);
        for (int j = 0; j < 2; j++) begin
          lvl[p] <= j[0];
          repeat (3) @(posedge CORE_CLK);
          st(k == j ? 16'h0001 << (15 - 2 * p) : 16'h0000);
        end
      end
    $display("test pins done");
    apb(1, ADDR_ARMS, 32'h0000_000F, 0);
    for (int e = 0; e < 4; e++)
      for (int m = 0; m < 2; m++) begin
        RECEIVE_CHAR_COUNT_USED <= m[0];
        BIPHASE_MODE <= m[0];
        ev[e] <= 1;
        @(posedge CORE_CLK) ev[e] <= 0;
        repeat (2) @(posedge CORE_CLK);
        st(m == 1 || e < 2 ? 16'h0001 << e : 16'h0000);
      end
    $display("test events done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
